// ==== verilog/afe_pkg.sv ====
// constants, operation codes and status bit layout shared by the execute block
// assumes one system clock; the core around it owns the register file and stack
package afe_pkg;

	// clock rate of the core
	localparam int unsigned CLK_HZ = 20_000_000;

	// cycle counts per operation class
	localparam logic [2:0] CYC_ALU  = 3'h1;
	localparam logic [2:0] CYC_WORD = 3'h2;
	localparam logic [2:0] CYC_JMP  = 3'h2;
	localparam logic [2:0] CYC_CALL = 3'h3;
	localparam logic [2:0] CYC_RET  = 3'h4;
	localparam logic [2:0] CYC_SKIP = 3'h2;

	// status register bit positions
	localparam int SR_C = 0;
	localparam int SR_Z = 1;
	localparam int SR_N = 2;
	localparam int SR_V = 3;
	localparam int SR_S = 4;
	localparam int SR_H = 5;
	localparam int SR_T = 6;
	localparam int SR_I = 7;

	// flag update masks
	localparam logic [7:0] MSK_NONE  = 8'h00;
	localparam logic [7:0] MSK_ZNV   = 8'h0E;
	localparam logic [7:0] MSK_ZCNV  = 8'h0F;
	localparam logic [7:0] MSK_ZCNVH = 8'h2F;
	localparam logic [7:0] MSK_ZCNVS = 8'h1F;

	// byte constants
	localparam logic [7:0] BYTE_ONES = 8'hFF;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONE  = 8'h01;

	// operation codes presented by the decoder
	typedef enum logic [5:0] {
		OP_SUM_TWO_REGS, OP_SUM_WITH_CARRY_IN, OP_WORD_IMMEDIATE_PLUS,
		OP_DIFFERENCE_REGS, OP_DIFFERENCE_CONST, OP_DIFFERENCE_REGS_BORROW,
		OP_DIFFERENCE_CONST_BORROW, OP_WORD_IMMEDIATE_MINUS,
		OP_BITWISE_CONJ_REGS, OP_BITWISE_CONJ_CONST, OP_BITWISE_DISJ_REGS,
		OP_BITWISE_DISJ_CONST, OP_BITWISE_XDISJ_REGS, OP_ONES_INVERT,
		OP_TWOS_INVERT, OP_BITS_SET_MASK, OP_BITS_CLEAR_MASK, OP_PLUS_ONE,
		OP_MINUS_ONE, OP_ZERO_SIGN_TEST, OP_ZERO_FILL, OP_ALL_ONES_FILL,
		OP_RELATIVE_JUMP, OP_POINTER_JUMP, OP_RELATIVE_CALL, OP_POINTER_CALL,
		OP_SUBROUTINE_BACK, OP_INTERRUPT_BACK, OP_EQUAL_SKIP, OP_COMPARE_REGS,
		OP_COMPARE_REGS_BORROW, OP_COMPARE_CONST, OP_SKIP_IF_BIT_LOW
	} afe_op_t;

	// byte unit functions
	typedef enum logic [2:0] {
		FN_ADD, FN_SUB, FN_AND, FN_OR, FN_XOR, FN_COM
	} afe_fn_t;

	// sequencer states, one-hot
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} afe_state_t;

endpackage : afe_pkg

// ==== verilog/afe_alu_if.sv ====
// operand and result bundle between the sequencer and its two arithmetic units
// assumes the units are purely combinational
`timescale 1ns/1ns
interface afe_alu_if;
	import afe_pkg::*;

	// byte unit
	afe_fn_t     fn;
	logic [7:0]  a;
	logic [7:0]  b;
	logic        cin;
	logic        zin;
	logic        zchain;
	logic [7:0]  res;
	logic [7:0]  flg;
	// word unit
	logic [15:0] w_in;
	logic [5:0]  k;
	logic        w_sub;
	logic [15:0] w_res;
	logic [7:0]  w_flg;

	modport core (output fn, a, b, cin, zin, zchain, w_in, k, w_sub,
		input res, flg, w_res, w_flg);
	modport byte_unit (input fn, a, b, cin, zin, zchain, output res, flg);
	modport word_unit (input w_in, k, w_sub, output w_res, w_flg);
endinterface : afe_alu_if

// ==== verilog/afe_alu8.sv ====
// byte arithmetic and logic unit with status flag generation
// assumes the caller merges the flags it is allowed to change
`timescale 1ns/1ns
module afe_alu8
	import afe_pkg::*;
(
	afe_alu_if.byte_unit bus
);

	logic [8:0] wide;
	logic [7:0] a;
	logic [7:0] b;
	logic [7:0] r;

	// add and subtract each form the 9-bit wide result; carry out of bit 7 is borrow on subtract
	always_comb
	begin
		a    = bus.a;
		b    = bus.b;
		wide = 9'h000;
		r    = 8'h00;
		bus.flg = 8'h00;
		case (bus.fn)
			FN_ADD:
			begin
				wide = {1'b0, a} + {1'b0, b} + {8'h00, bus.cin};
				r    = wide[7:0];
				bus.flg[SR_C] = wide[8];
				bus.flg[SR_H] = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
				bus.flg[SR_V] = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
			end
			FN_SUB:
			begin
				wide = {1'b0, a} - {1'b0, b} - {8'h00, bus.cin};
				r    = wide[7:0];
				bus.flg[SR_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
				bus.flg[SR_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
				bus.flg[SR_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
			end
			FN_AND: r = a & b;
			FN_OR:  r = a | b;
			FN_XOR: r = a ^ b;
			FN_COM:
			begin
				r = ~a;
				bus.flg[SR_C] = 1'b1;
			end
			default: r = a;
		endcase
		bus.flg[SR_N] = r[7];
		// chained subtract keeps zero only if the earlier byte was zero too
		bus.flg[SR_Z] = (r == BYTE_ZERO) & (~bus.zchain | bus.zin);
		bus.flg[SR_S] = r[7] ^ bus.flg[SR_V];
		bus.res = r;
	end

endmodule : afe_alu8

// ==== verilog/afe_word16.sv ====
// word add and subtract of a small immediate on a register pair
// assumes the immediate is zero extended
`timescale 1ns/1ns
module afe_word16
	import afe_pkg::*;
(
	afe_alu_if.word_unit bus
);

	logic [15:0] r;

	// pair arithmetic; only bit 15 matters for carry and overflow
	always_comb
	begin
		bus.w_flg = 8'h00;
		if (bus.w_sub)
		begin
			r = bus.w_in - {10'h000, bus.k};
			bus.w_flg[SR_V] = bus.w_in[15] & ~r[15];
			bus.w_flg[SR_C] = r[15] & ~bus.w_in[15];
		end
		else
		begin
			r = bus.w_in + {10'h000, bus.k};
			bus.w_flg[SR_V] = ~bus.w_in[15] & r[15];
			bus.w_flg[SR_C] = ~r[15] & bus.w_in[15];
		end
		bus.w_flg[SR_N] = r[15];
		bus.w_flg[SR_Z] = (r == 16'h0000);
		bus.w_flg[SR_S] = r[15] ^ bus.w_flg[SR_V];
		bus.w_res = r;
	end

endmodule : afe_word16

// ==== verilog/afe_exec_top.sv ====
// execute stage: arithmetic, logic, compare, skip and program flow operations
// assumes the decoder presents operands with i_start and holds nothing after
`timescale 1ns/1ns
module afe_exec_top
	import afe_pkg::*;
#(
	parameter int PC_W  = 12,
	parameter int OFF_W = 12
)
(
	// clock and reset
	input  wire logic             i_ref_clk,
	input  wire logic             i_rstn,
	// request from the decoder
	input  wire logic             i_start,
	input  wire afe_op_t          i_op,
	input  wire logic [7:0]       i_rd,
	input  wire logic [7:0]       i_rr,
	input  wire logic [7:0]       i_imm8,
	input  wire logic [5:0]       i_imm6,
	input  wire logic [2:0]       i_bit_sel,
	input  wire logic [15:0]      i_word,
	input  wire logic [7:0]       i_sreg,
	// program flow inputs
	input  wire logic [PC_W-1:0]  i_pc,
	input  wire logic [OFF_W-1:0] i_offset,
	input  wire logic [15:0]      i_z,
	input  wire logic [PC_W-1:0]  i_stack_pc,
	input  wire logic             i_next_two_word,
	// completion and results
	output logic                  o_busy,
	output logic                  o_done,
	output logic [7:0]            o_result8,
	output logic [15:0]           o_result16,
	output logic                  o_wr_byte,
	output logic                  o_wr_word,
	output logic [7:0]            o_sreg,
	output logic [PC_W-1:0]       o_pc,
	output logic                  o_push,
	output logic [PC_W-1:0]       o_push_pc,
	output logic                  o_pop
);

	// refuse widths the pointer and offset paths cannot serve
	if (PC_W < 2 || PC_W > 16 || OFF_W < 2 || OFF_W > PC_W)
	begin : g_bad_width
		$error("afe_exec_top: unsupported PC_W or OFF_W");
	end

	typedef struct packed {
		afe_state_t      st;
		logic [2:0]      cnt;
		logic            done;
		logic [7:0]      res8;
		logic [15:0]     res16;
		logic            wr8;
		logic            wr16;
		logic [7:0]      sreg;
		logic [PC_W-1:0] pc;
		logic            push;
		logic [PC_W-1:0] push_pc;
		logic            pop;
		logic            p_wr8;
		logic            p_wr16;
		logic            p_push;
		logic            p_pop;
	} afe_core_t;

	afe_core_t s_ff;
	afe_core_t nxt_s;

	afe_alu_if alu_bus ();

	afe_alu8 u_alu8 (
		.bus (alu_bus.byte_unit)
	);

	afe_word16 u_word16 (
		.bus (alu_bus.word_unit)
	);

	logic            take;
	logic [2:0]      cyc;
	logic [7:0]      mask;
	logic [7:0]      new_flg;
	logic            d_wr8;
	logic            d_wr16;
	logic            d_push;
	logic            d_pop;
	logic            set_i;
	logic            skip;
	logic [PC_W-1:0] pc_step;
	logic [PC_W-1:0] pc_rel;
	logic [PC_W-1:0] pc_nxt;

	assign take    = i_start & s_ff.st[1] == 1'b0;
	assign pc_step = i_pc + PC_W'(1);
	// offset is signed; sign extension before adding gives backward jumps
	assign pc_rel  = pc_step + PC_W'($signed(i_offset));

	////////////////////////////////////////////////////////////////////////
	// operation decode: operands, flag mask, cycle count, side effects
	always_comb
	begin
		alu_bus.fn     = FN_ADD;
		alu_bus.a      = i_rd;
		alu_bus.b      = i_rr;
		alu_bus.cin    = 1'b0;
		alu_bus.zin    = i_sreg[SR_Z];
		alu_bus.zchain = 1'b0;
		alu_bus.w_in   = i_word;
		alu_bus.k      = i_imm6;
		alu_bus.w_sub  = 1'b0;
		mask    = MSK_NONE;
		new_flg = alu_bus.flg;
		cyc     = CYC_ALU;
		d_wr8   = 1'b1;
		d_wr16  = 1'b0;
		d_push  = 1'b0;
		d_pop   = 1'b0;
		set_i   = 1'b0;
		skip    = 1'b0;
		pc_nxt  = pc_step;
		case (i_op)
			OP_SUM_TWO_REGS:      mask = MSK_ZCNVH;
			OP_SUM_WITH_CARRY_IN:
			begin
				alu_bus.cin = i_sreg[SR_C];
				mask        = MSK_ZCNVH;
			end
			OP_WORD_IMMEDIATE_PLUS, OP_WORD_IMMEDIATE_MINUS:
			begin
				alu_bus.w_sub = (i_op == OP_WORD_IMMEDIATE_MINUS);
				new_flg       = alu_bus.w_flg;
				mask          = MSK_ZCNVS;
				cyc           = CYC_WORD;
				d_wr8         = 1'b0;
				d_wr16        = 1'b1;
			end
			OP_DIFFERENCE_REGS, OP_DIFFERENCE_CONST, OP_COMPARE_REGS,
			OP_COMPARE_CONST:
			begin
				alu_bus.fn = FN_SUB;
				if (i_op == OP_DIFFERENCE_CONST || i_op == OP_COMPARE_CONST)
					alu_bus.b = i_imm8;
				mask  = MSK_ZCNVH;
				// compares only set flags
				d_wr8 = (i_op == OP_DIFFERENCE_REGS || i_op == OP_DIFFERENCE_CONST);
			end
			OP_DIFFERENCE_REGS_BORROW, OP_DIFFERENCE_CONST_BORROW,
			OP_COMPARE_REGS_BORROW:
			begin
				alu_bus.fn     = FN_SUB;
				alu_bus.cin    = i_sreg[SR_C];
				alu_bus.zchain = 1'b1;
				if (i_op == OP_DIFFERENCE_CONST_BORROW)
					alu_bus.b = i_imm8;
				mask  = MSK_ZCNVH;
				d_wr8 = (i_op != OP_COMPARE_REGS_BORROW);
			end
			OP_BITWISE_CONJ_REGS, OP_BITWISE_CONJ_CONST, OP_BITS_CLEAR_MASK,
			OP_ZERO_SIGN_TEST:
			begin
				alu_bus.fn = FN_AND;
				if (i_op == OP_BITWISE_CONJ_CONST)
					alu_bus.b = i_imm8;
				else if (i_op == OP_BITS_CLEAR_MASK)
					alu_bus.b = BYTE_ONES - i_imm8;
				else if (i_op == OP_ZERO_SIGN_TEST)
					alu_bus.b = i_rd;
				mask = MSK_ZNV;
			end
			OP_BITWISE_DISJ_REGS, OP_BITWISE_DISJ_CONST, OP_BITS_SET_MASK:
			begin
				alu_bus.fn = FN_OR;
				if (i_op != OP_BITWISE_DISJ_REGS)
					alu_bus.b = i_imm8;
				mask = MSK_ZNV;
			end
			OP_BITWISE_XDISJ_REGS, OP_ZERO_FILL:
			begin
				alu_bus.fn = FN_XOR;
				if (i_op == OP_ZERO_FILL)
					alu_bus.b = i_rd;
				mask = MSK_ZNV;
			end
			OP_ONES_INVERT:
			begin
				alu_bus.fn = FN_COM;
				mask       = MSK_ZCNV;
			end
			OP_TWOS_INVERT:
			begin
				alu_bus.fn = FN_SUB;
				alu_bus.a  = BYTE_ZERO;
				alu_bus.b  = i_rd;
				mask       = MSK_ZCNVH;
			end
			OP_PLUS_ONE, OP_MINUS_ONE:
			begin
				alu_bus.fn = (i_op == OP_MINUS_ONE) ? FN_SUB : FN_ADD;
				alu_bus.b  = BYTE_ONE;
				mask       = MSK_ZNV;
			end
			OP_ALL_ONES_FILL:
			begin
				alu_bus.fn = FN_OR;
				alu_bus.b  = BYTE_ONES;
			end
			OP_RELATIVE_JUMP, OP_POINTER_JUMP:
			begin
				cyc    = CYC_JMP;
				d_wr8  = 1'b0;
				pc_nxt = (i_op == OP_POINTER_JUMP) ? i_z[PC_W-1:0] : pc_rel;
			end
			OP_RELATIVE_CALL, OP_POINTER_CALL:
			begin
				cyc    = CYC_CALL;
				d_wr8  = 1'b0;
				d_push = 1'b1;
				pc_nxt = (i_op == OP_POINTER_CALL) ? i_z[PC_W-1:0] : pc_rel;
			end
			OP_SUBROUTINE_BACK, OP_INTERRUPT_BACK:
			begin
				cyc    = CYC_RET;
				d_wr8  = 1'b0;
				d_pop  = 1'b1;
				set_i  = (i_op == OP_INTERRUPT_BACK);
				pc_nxt = i_stack_pc;
			end
			OP_EQUAL_SKIP, OP_SKIP_IF_BIT_LOW:
			begin
				d_wr8 = 1'b0;
				skip  = (i_op == OP_EQUAL_SKIP) ? (i_rd == i_rr)
					: ~i_rr[i_bit_sel];
				// a taken skip passes the whole next instruction
				if (skip)
				begin
					cyc    = CYC_SKIP + {2'b00, i_next_two_word};
					pc_nxt = pc_step + PC_W'(cyc - CYC_ALU);
				end
			end
			default: d_wr8 = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer: data outputs load on acceptance, strobes rise on the last cycle
	always_comb
	begin
		nxt_s      = s_ff;
		nxt_s.done = 1'b0;
		nxt_s.wr8  = 1'b0;
		nxt_s.wr16 = 1'b0;
		nxt_s.push = 1'b0;
		nxt_s.pop  = 1'b0;
		case (s_ff.st)
			ST_IDLE:
			begin
				if (take)
				begin
					nxt_s.res8    = alu_bus.res;
					nxt_s.res16   = alu_bus.w_res;
					nxt_s.sreg    = (i_sreg & ~mask) | (new_flg & mask);
					nxt_s.sreg[SR_I] = i_sreg[SR_I] | set_i;
					nxt_s.pc      = pc_nxt;
					nxt_s.push_pc = pc_step;
					nxt_s.p_wr8   = d_wr8;
					nxt_s.p_wr16  = d_wr16;
					nxt_s.p_push  = d_push;
					nxt_s.p_pop   = d_pop;
					// single cycle work completes at the next edge
					if (cyc == CYC_ALU)
					begin
						nxt_s.done = 1'b1;
						nxt_s.wr8  = d_wr8;
					end
					else
					begin
						nxt_s.st  = ST_BUSY;
						nxt_s.cnt = cyc - 3'h2;
					end
				end
			end
			ST_BUSY:
			begin
				if (s_ff.cnt == 3'h0)
				begin
					nxt_s.st   = ST_IDLE;
					nxt_s.done = 1'b1;
					nxt_s.wr8  = s_ff.p_wr8;
					nxt_s.wr16 = s_ff.p_wr16;
					nxt_s.push = s_ff.p_push;
					nxt_s.pop  = s_ff.p_pop;
				end
				else
					nxt_s.cnt = s_ff.cnt - 3'h1;
			end
			default: nxt_s.st = ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			s_ff    <= '0;
			s_ff.st <= ST_IDLE;
		end
		else
			s_ff <= nxt_s;
	end

	// outputs are flop bits
	assign o_busy     = s_ff.st[1];
	assign o_done     = s_ff.done;
	assign o_result8  = s_ff.res8;
	assign o_result16 = s_ff.res16;
	assign o_wr_byte  = s_ff.wr8;
	assign o_wr_word  = s_ff.wr16;
	assign o_sreg     = s_ff.sreg;
	assign o_pc       = s_ff.pc;
	assign o_push     = s_ff.push;
	assign o_push_pc  = s_ff.push_pc;
	assign o_pop      = s_ff.pop;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);

	sequence s_wait1;
		!o_done ##1 o_done;
	endsequence
	sequence s_wait3;
		!o_done [*3] ##1 o_done;
	endsequence

	a_sum_value: assert property (take && i_op == OP_SUM_TWO_REGS
		|=> o_done && o_wr_byte && o_result8 == 8'($past(i_rd) + $past(i_rr)))
		else $error("sum result or timing wrong");
	a_word_two_cycles: assert property (take && i_op == OP_WORD_IMMEDIATE_PLUS
		|=> s_wait1 ##0 o_wr_word)
		else $error("word add not two cycles");
	a_word_minus_val: assert property (take && i_op == OP_WORD_IMMEDIATE_MINUS
		|-> ##2 o_result16 == 16'($past(i_word, 2) - $past(i_imm6, 2)))
		else $error("word subtract wrong");
	a_sub_borrow: assert property (take && i_op == OP_DIFFERENCE_REGS
		|=> o_sreg[SR_C] == ($past(i_rr) > $past(i_rd)))
		else $error("subtract carry wrong");
	a_borrow_in: assert property (take && i_op == OP_DIFFERENCE_REGS_BORROW
		|=> o_result8 == 8'($past(i_rd) - $past(i_rr) - $past(i_sreg[SR_C])))
		else $error("subtract with carry wrong");
	a_logic_keeps_c: assert property (take && i_op == OP_BITWISE_CONJ_REGS
		|=> !o_sreg[SR_V] && o_sreg[SR_C] == $past(i_sreg[SR_C]))
		else $error("logic flags wrong");
	a_xor_zero: assert property (take && i_op == OP_ZERO_FILL
		|=> o_result8 == BYTE_ZERO && o_sreg[SR_Z])
		else $error("zero fill wrong");
	a_invert_carry: assert property (take && i_op == OP_ONES_INVERT
		|=> o_sreg[SR_C] && o_result8 == ~$past(i_rd))
		else $error("ones complement wrong");
	a_fill_keeps: assert property (take && i_op == OP_ALL_ONES_FILL
		|=> o_result8 == BYTE_ONES && o_sreg == $past(i_sreg))
		else $error("fill ones changed flags");
	a_jump_two: assert property (take && i_op == OP_POINTER_JUMP
		|=> s_wait1 ##0 o_pc == $past(i_z[PC_W-1:0], 2))
		else $error("pointer jump wrong");
	a_ret_four: assert property (take && i_op == OP_INTERRUPT_BACK
		|=> s_wait3 ##0 o_pop && o_sreg[SR_I])
		else $error("interrupt return wrong");
	a_compare_nowr: assert property (take && i_op == OP_COMPARE_CONST
		|=> o_done && !o_wr_byte)
		else $error("compare wrote result");
	a_skip_len: assert property (take && i_op == OP_EQUAL_SKIP && i_rd == i_rr
		&& i_next_two_word |-> ##3 o_done && o_pc == PC_W'($past(i_pc, 3) + 3))
		else $error("skip length wrong");
	a_bit_noskip: assert property (take && i_op == OP_SKIP_IF_BIT_LOW
		&& i_rr[i_bit_sel] |=> o_done && o_pc == PC_W'($past(i_pc) + 1))
		else $error("bit skip taken wrongly");

endmodule : afe_exec_top

// ==== dv/test_alu_and_flow_exec.sv ====
// self-checking bench for the execute stage: byte, word, flow and skip operations
// assumes the decoder side is driven here directly; no model beyond the bench
`timescale 1ns/1ns
module test_alu_and_flow_exec;
	import afe_pkg::*;

	localparam logic [11:0] PC  = 12'h100;
	localparam logic [11:0] OFF = 12'hFF0;
	localparam logic [15:0] ZP  = 16'hF234;
	localparam logic [11:0] STK = 12'h0AB;
	localparam logic [11:0] REL = PC + OFF + 12'h001;

	logic        i_ref_clk, i_rstn, i_start, i_next_two_word;
	afe_op_t     i_op;
	logic [7:0]  i_rd, i_rr, i_imm8, i_sreg, o_result8, o_sreg;
	logic [5:0]  i_imm6;
	logic [2:0]  i_bit_sel;
	logic [15:0] i_word, i_z, o_result16;
	logic [11:0] i_pc, i_offset, i_stack_pc, o_pc, o_push_pc;
	logic        o_busy, o_done, o_wr_byte, o_wr_word, o_push, o_pop;
	logic [15:0] nx_word;
	logic [5:0]  nx_imm6;
	logic [2:0]  nx_bit;
	logic        nx_two;
	int          miscompares, cmp_count, cyc;

	afe_exec_top #(.PC_W(12), .OFF_W(12)) dut (
		.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_start(i_start), .i_op(i_op),
		.i_rd(i_rd), .i_rr(i_rr), .i_imm8(i_imm8), .i_imm6(i_imm6),
		.i_bit_sel(i_bit_sel), .i_word(i_word), .i_sreg(i_sreg), .i_pc(i_pc),
		.i_offset(i_offset), .i_z(i_z), .i_stack_pc(i_stack_pc),
		.i_next_two_word(i_next_two_word), .o_busy(o_busy), .o_done(o_done),
		.o_result8(o_result8), .o_result16(o_result16), .o_wr_byte(o_wr_byte),
		.o_wr_word(o_wr_word), .o_sreg(o_sreg), .o_pc(o_pc), .o_push(o_push),
		.o_push_pc(o_push_pc), .o_pop(o_pop));

	////////////////////////////////////////////////////////////////////////////
	// 20 MHz clock
	initial
	begin
		i_ref_clk = 1'b0;
		forever #25 i_ref_clk = ~i_ref_clk;
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic final_report;
		if (miscompares == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report

	// one request, held a single cycle; waits for done under a bound
	task automatic go(input afe_op_t op, input logic [7:0] rd, input logic [7:0] rr,
		input logic [7:0] k, input logic [7:0] s);
		@(posedge i_ref_clk);
		i_op <= op;
		i_rd <= rd;
		i_rr <= rr;
		i_imm8 <= k;
		i_sreg <= s;
		i_word <= nx_word;
		i_imm6 <= nx_imm6;
		i_bit_sel <= nx_bit;
		i_next_two_word <= nx_two;
		i_start <= 1'b1;
		cyc = 0;
		repeat (8)
		begin
			@(posedge i_ref_clk);
			i_start <= 1'b0;
			#1;
			cyc++;
			if (o_done === 1'b1)
				break;
		end
	endtask : go

	////////////////////////////////////////////////////////////////////////////
	// byte reference: {write, result, status}; g holds the carry chain per bit
	function automatic logic [16:0] ref8(input afe_op_t op, input logic [7:0] a,
		input logic [7:0] b, input logic [7:0] s);
		logic [7:0] p, x, r, f, g, v;
		logic       cy, ad, sb, bw;
		ad = op inside {OP_SUM_TWO_REGS, OP_SUM_WITH_CARRY_IN, OP_PLUS_ONE};
		sb = op inside {OP_DIFFERENCE_REGS, OP_DIFFERENCE_CONST, OP_DIFFERENCE_REGS_BORROW,
			OP_DIFFERENCE_CONST_BORROW, OP_COMPARE_REGS, OP_COMPARE_REGS_BORROW,
			OP_COMPARE_CONST, OP_TWOS_INVERT, OP_MINUS_ONE};
		bw = op inside {OP_DIFFERENCE_REGS_BORROW, OP_DIFFERENCE_CONST_BORROW,
			OP_COMPARE_REGS_BORROW};
		cy = (bw | (op == OP_SUM_WITH_CARRY_IN)) & s[SR_C];
		p = (op == OP_TWOS_INVERT) ? BYTE_ZERO : a;
		// self operations and the unit step never look at the second register
		x = (op inside {OP_TWOS_INVERT, OP_ZERO_SIGN_TEST, OP_ZERO_FILL}) ? a
			: (op inside {OP_PLUS_ONE, OP_MINUS_ONE}) ? BYTE_ONE : b;
		case (op)
			OP_BITWISE_CONJ_REGS, OP_BITWISE_CONJ_CONST, OP_ZERO_SIGN_TEST: r = a & x;
			OP_BITWISE_DISJ_REGS, OP_BITWISE_DISJ_CONST, OP_BITS_SET_MASK: r = a | x;
			OP_BITWISE_XDISJ_REGS, OP_ZERO_FILL: r = a ^ x;
			OP_BITS_CLEAR_MASK: r = a & (BYTE_ONES - x);
			OP_ONES_INVERT: r = BYTE_ONES - a;
			OP_ALL_ONES_FILL: r = BYTE_ONES;
			default: r = sb ? p - x - cy : p + x + cy;
		endcase
		g = ad ? (p & x) | (x & ~r) | (~r & p) : (~p & x) | (x & r) | (r & ~p);
		v = ad ? (p & x & ~r) | (~p & ~x & r) : (p & ~x & ~r) | (~p & x & r);
		f = s;
		f[SR_Z] = (r == BYTE_ZERO) & (s[SR_Z] | ~bw);
		f[SR_N] = r[7];
		f[SR_V] = (ad | sb) & v[7];
		if ((ad | sb) && !(op inside {OP_PLUS_ONE, OP_MINUS_ONE}))
			f = {f[7:6], g[3], f[4:1], g[7]};
		if (op == OP_ONES_INVERT)
			f[SR_C] = 1'b1;
		if (op == OP_ALL_ONES_FILL)
			f = s;
		return {~(op inside {OP_COMPARE_REGS, OP_COMPARE_REGS_BORROW, OP_COMPARE_CONST}), r, f};
	endfunction : ref8

	// byte case; the operand goes to the constant or the register, the other gets its inverse
	task automatic byte_case(input afe_op_t op, input logic [7:0] a, input logic [7:0] x,
		input logic usek, input logic [7:0] s);
		logic [16:0] e;
		e = ref8(op, a, x, s);
		go(op, a, usek ? ~x : x, usek ? x : ~x, s);
		chk("byte cycles", cyc, 32'h1);
		chk("byte write", o_wr_byte, e[16]);
		if (e[16])
			chk("result8", o_result8, e[15:8]);
		chk("sreg", o_sreg, e[7:0]);
		chk("next pc", o_pc, PC + 12'h001);
	endtask : byte_case

	// word add or subtract of a zero-extended immediate
	task automatic word_case(input logic sub, input logic [15:0] w, input logic [5:0] k,
		input logic [7:0] s);
		logic [15:0] r;
		logic [7:0]  f;
		r = sub ? w - {10'h000, k} : w + {10'h000, k};
		f = s;
		f[SR_Z] = (r == 16'h0000);
		f[SR_N] = r[15];
		f[SR_V] = sub ? w[15] & ~r[15] : ~w[15] & r[15];
		f[SR_C] = sub ? r[15] & ~w[15] : ~r[15] & w[15];
		f[SR_S] = f[SR_N] ^ f[SR_V];
		nx_word = w;
		nx_imm6 = k;
		go(sub ? OP_WORD_IMMEDIATE_MINUS : OP_WORD_IMMEDIATE_PLUS, 8'h00, 8'h00, 8'h00, s);
		chk("word cycles", cyc, 32'h2);
		chk("word write", {o_wr_word, o_wr_byte}, 2'h2);
		chk("result16", o_result16, r);
		chk("word sreg", o_sreg, f);
	endtask : word_case

	// flow and skip case; pp is {push, pop}
	task automatic flow_case(input afe_op_t op, input logic [7:0] rd, input logic [7:0] rr,
		input logic [7:0] s, input logic [2:0] n, input logic [11:0] pc_e,
		input logic [7:0] s_e, input logic [1:0] pp);
		go(op, rd, rr, 8'h00, s);
		chk("flow cycles", cyc, n);
		chk("flow pc", o_pc, pc_e);
		chk("flow sreg", o_sreg, s_e);
		chk("push pop", {o_push, o_pop}, pp);
		if (pp[1])
			chk("return addr", o_push_pc, PC + 12'h001);
	endtask : flow_case

	// start held high through a return: ignored while busy, taken in the done cycle
	task automatic busy_case;
		@(posedge i_ref_clk);
		i_op <= OP_SUBROUTINE_BACK;
		i_start <= 1'b1;
		@(posedge i_ref_clk);
		i_op <= OP_SUM_TWO_REGS;
		i_rd <= 8'h21;
		i_rr <= 8'h12;
		for (int i = 2; i <= 4; i++)
		begin
			@(posedge i_ref_clk);
			#1;
			chk("done while busy", o_done, i == 4);
			chk("busy level", o_busy, i != 4);
		end
		chk("pop", {o_pop, o_pc}, {1'b1, STK});
		@(posedge i_ref_clk);
		i_start <= 1'b0;
		#1;
		chk("sum after return", {o_done, o_result8}, 9'h133);
	endtask : busy_case

	////////////////////////////////////////////////////////////////////////////
	// watchdog: the whole sequence needs about a hundred cycles
	initial
	begin
		#(2000 * 50);
		miscompares++;
		final_report();
	end

	// main sequence
	initial
	begin
		{i_start, i_rd, i_rr, i_imm8, i_imm6, i_bit_sel, i_word, i_sreg} = '0;
		{i_next_two_word, nx_word, nx_imm6, nx_bit, nx_two} = '0;
		i_op = OP_SUM_TWO_REGS;
		i_pc = PC;
		i_offset = OFF;
		i_z = ZP;
		i_stack_pc = STK;
		miscompares = 0;
		cmp_count = 0;
		i_rstn = 1'b0;
		repeat (5) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		byte_case(OP_SUM_TWO_REGS, 8'h7F, 8'h01, 1'b0, 8'h00);
		byte_case(OP_SUM_WITH_CARRY_IN, 8'hFF, 8'h00, 1'b0, 8'h01);
		byte_case(OP_DIFFERENCE_REGS, 8'h10, 8'h20, 1'b0, 8'h02);
		byte_case(OP_DIFFERENCE_CONST, 8'h80, 8'h01, 1'b1, 8'h00);
		byte_case(OP_DIFFERENCE_REGS_BORROW, 8'h05, 8'h05, 1'b0, 8'h01);
		byte_case(OP_DIFFERENCE_CONST_BORROW, 8'h05, 8'h04, 1'b1, 8'h03);
		byte_case(OP_BITWISE_CONJ_REGS, 8'h5A, 8'h0F, 1'b0, 8'hFF);
		byte_case(OP_BITWISE_CONJ_CONST, 8'hF0, 8'h0F, 1'b1, 8'h00);
		byte_case(OP_BITWISE_DISJ_REGS, 8'h80, 8'h01, 1'b0, 8'h08);
		byte_case(OP_BITWISE_DISJ_CONST, 8'h00, 8'h00, 1'b1, 8'h21);
		byte_case(OP_BITWISE_XDISJ_REGS, 8'hAA, 8'hFF, 1'b0, 8'h00);
		byte_case(OP_ONES_INVERT, 8'h0F, 8'h00, 1'b0, 8'h20);
		byte_case(OP_TWOS_INVERT, 8'h01, 8'h00, 1'b0, 8'h00);
		byte_case(OP_TWOS_INVERT, 8'h80, 8'h00, 1'b0, 8'h00);
		byte_case(OP_BITS_SET_MASK, 8'h01, 8'h80, 1'b1, 8'h00);
		byte_case(OP_BITS_CLEAR_MASK, 8'hFF, 8'h0F, 1'b1, 8'h08);
		byte_case(OP_ALL_ONES_FILL, 8'h12, 8'h00, 1'b0, 8'h3C);
		byte_case(OP_PLUS_ONE, 8'h7F, 8'h33, 1'b0, 8'h21);
		byte_case(OP_MINUS_ONE, 8'h80, 8'h33, 1'b0, 8'h00);
		byte_case(OP_ZERO_SIGN_TEST, 8'h80, 8'h7F, 1'b0, 8'h0C);
		byte_case(OP_ZERO_FILL, 8'h5A, 8'hA5, 1'b0, 8'h04);
		byte_case(OP_COMPARE_REGS, 8'h40, 8'h40, 1'b0, 8'h00);
		byte_case(OP_COMPARE_REGS_BORROW, 8'h00, 8'h00, 1'b0, 8'h01);
		byte_case(OP_COMPARE_CONST, 8'h30, 8'h31, 1'b1, 8'h00);
		word_case(1'b0, 16'hFFFF, 6'h01, 8'h00);
		word_case(1'b0, 16'h7FFF, 6'h01, 8'h20);
		word_case(1'b1, 16'h0000, 6'h01, 8'h00);
		word_case(1'b1, 16'h8000, 6'h3F, 8'h00);
		flow_case(OP_RELATIVE_JUMP, 8'h00, 8'h00, 8'h5A, 3'h2, REL, 8'h5A, 2'h0);
		flow_case(OP_POINTER_JUMP, 8'h00, 8'h00, 8'h5A, 3'h2, ZP[11:0], 8'h5A, 2'h0);
		flow_case(OP_RELATIVE_CALL, 8'h00, 8'h00, 8'h5A, 3'h3, REL, 8'h5A, 2'h2);
		flow_case(OP_POINTER_CALL, 8'h00, 8'h00, 8'h5A, 3'h3, ZP[11:0], 8'h5A, 2'h2);
		flow_case(OP_SUBROUTINE_BACK, 8'h00, 8'h00, 8'h5A, 3'h4, STK, 8'h5A, 2'h1);
		flow_case(OP_INTERRUPT_BACK, 8'h00, 8'h00, 8'h5A, 3'h4, STK, 8'hDA, 2'h1);
		flow_case(OP_EQUAL_SKIP, 8'h3C, 8'h3C, 8'h5A, 3'h2, PC + 12'h002, 8'h5A, 2'h0);
		flow_case(OP_EQUAL_SKIP, 8'h3C, 8'h3D, 8'h5A, 3'h1, PC + 12'h001, 8'h5A, 2'h0);
		nx_two = 1'b1;
		nx_bit = 3'h5;
		flow_case(OP_EQUAL_SKIP, 8'h3C, 8'h3C, 8'h5A, 3'h3, PC + 12'h003, 8'h5A, 2'h0);
		flow_case(OP_SKIP_IF_BIT_LOW, 8'h00, 8'hDF, 8'hA5, 3'h3, PC + 12'h003, 8'hA5, 2'h0);
		nx_two = 1'b0;
		flow_case(OP_SKIP_IF_BIT_LOW, 8'h00, 8'hDF, 8'hA5, 3'h2, PC + 12'h002, 8'hA5, 2'h0);
		flow_case(OP_SKIP_IF_BIT_LOW, 8'hFF, 8'h20, 8'hA5, 3'h1, PC + 12'h001, 8'hA5, 2'h0);
		busy_case();
		final_report();
	end

endmodule : test_alu_and_flow_exec
